// ==== include/wake_timer_pkg.sv ====
package wake_timer_pkg;
	// register byte offsets (low address bits only)
	localparam logic [3:0] OFS_CONTROL_STATUS = 4'h0;
	localparam logic [3:0] OFS_PRESCALER = 4'h4;
	localparam logic [3:0] OFS_TIMEBASE = 4'h8;
	// control/status field positions
	localparam int BIT_MEASURE_EN = 0;
	localparam int BIT_WAKE_EN = 4;
	localparam int BIT_WAKE_FLAG = 5;
	// reset values
	localparam logic [31:0] RST_CONTROL_STATUS = 32'h0000_0000;
	localparam logic [7:0] RST_PRESCALER = 8'hC0;
	localparam logic [3:0] RST_TIMEBASE = 4'h0;
	// timebase code that disables wakeup
	localparam logic [3:0] TB_OFF = 4'h0;
	// coefficient for the two irregular timebase codes
	localparam logic [3:0] TB_FIVE = 4'hE;
	localparam logic [3:0] TB_THIRTY = 4'hF;
	localparam logic [15:0] COEF_FIVE = 16'h2800;
	localparam logic [15:0] COEF_THIRTY = 16'hF000;
	localparam logic [15:0] COEF_ONE = 16'h0001;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/auto_wake_timer.sv ====
`timescale 1ns/10ps
module auto_wake_timer
	import wake_timer_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// slow clock pin and its measurement route
	input wire logic slow_internal_rc_clock,
	output logic capture_timer_one_ch1,
	// wakeup interrupt request
	output logic wake_irq
);
	// bus handshake state
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic [3:0] waddr_ff; // captured write address
	logic [31:0] wdata_ff; // captured write data
	logic [3:0] wstrb_ff; // captured byte enables
	// registers
	logic measure_en_ff, wake_en_ff, flag_ff;
	logic [7:0] presc_reg_ff; // bits 7:6 show reset marker until first write
	logic [3:0] tbc_ff;
	// slow clock synchroniser and edge detect
	logic slow_s1_ff, slow_s2_ff, slow_s3_ff;
	logic slow_edge;
	// counters
	logic [5:0] presc_cnt_ff;
	logic tick_ff;
	logic [15:0] wake_cnt_ff;
	logic expire_ff;
	logic capture_ff, irq_ff;
	logic run;
	logic [15:0] coef;
	logic wr_fire, rd_fire, rd_csts;

	// coefficient for a timebase code
	function automatic logic [15:0] coef_of(input logic [3:0] code);
		logic [15:0] c;
		c = COEF_ONE;
		case (code)
			TB_FIVE: c = COEF_FIVE;
			TB_THIRTY: c = COEF_THIRTY;
			TB_OFF: c = COEF_ONE;
			default: c = COEF_ONE << (code - 4'h1);
		endcase
		return c;
	endfunction

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rresp = rresp_ff;
	assign rdata = rdata_ff;
	assign capture_timer_one_ch1 = capture_ff;
	assign wake_irq = irq_ff;

	// both halves of a write held and no response pending
	assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
	assign rd_fire = arvalid && arready_ff;
	assign rd_csts = rd_fire && (araddr[3:0] == OFS_CONTROL_STATUS);
	assign run = wake_en_ff && (tbc_ff != TB_OFF);
	assign coef = coef_of(tbc_ff);
	assign slow_edge = slow_s2_ff && !slow_s3_ff;

	// write address channel, taken in any order with data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			waddr_ff <= 4'h0;
		end else if (awvalid && awready_ff) begin
			awready_ff <= 1'b0;
			waddr_ff <= awaddr[3:0];
		end else if (bvalid_ff && bready) begin
			awready_ff <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_ff <= 1'b1;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else if (wvalid && wready_ff) begin
			wready_ff <= 1'b0;
			wdata_ff <= wdata;
			wstrb_ff <= wstrb;
		end else if (bvalid_ff && bready) begin
			wready_ff <= 1'b1;
		end
	end

	// write response, error on unmapped offsets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= (waddr_ff == OFS_CONTROL_STATUS || waddr_ff == OFS_PRESCALER ||
				waddr_ff == OFS_TIMEBASE) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// register writes, only byte lane zero holds fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			measure_en_ff <= RST_CONTROL_STATUS[BIT_MEASURE_EN];
			wake_en_ff <= RST_CONTROL_STATUS[BIT_WAKE_EN];
			presc_reg_ff <= RST_PRESCALER;
			tbc_ff <= RST_TIMEBASE;
		end else if (wr_fire && wstrb_ff[0]) begin
			case (waddr_ff)
				OFS_CONTROL_STATUS: begin
					measure_en_ff <= wdata_ff[BIT_MEASURE_EN];
					wake_en_ff <= wdata_ff[BIT_WAKE_EN];
				end
				OFS_PRESCALER: presc_reg_ff <= {2'h0, wdata_ff[5:0]};
				OFS_TIMEBASE: tbc_ff <= wdata_ff[3:0];
				default: ;
			endcase
		end
	end

	// read channel, data taken at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OKAY;
		end else if (rd_fire) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rresp_ff <= RESP_OKAY;
			case (araddr[3:0])
				OFS_CONTROL_STATUS: rdata_ff <= {26'h0, flag_ff, wake_en_ff, 3'h0, measure_en_ff};
				OFS_PRESCALER: rdata_ff <= {24'h0, presc_reg_ff};
				OFS_TIMEBASE: rdata_ff <= {28'h0, tbc_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_ff && rready) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// slow clock synchroniser and edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_s1_ff <= 1'b0;
			slow_s2_ff <= 1'b0;
			slow_s3_ff <= 1'b0;
		end else begin
			slow_s1_ff <= slow_internal_rc_clock;
			slow_s2_ff <= slow_s1_ff;
			slow_s3_ff <= slow_s2_ff;
		end
	end

	// prescaler divides by code plus two, except code 63, where the 6-bit limit wraps to zero and it divides by one
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			presc_cnt_ff <= 6'h00;
			tick_ff <= 1'b0;
		end else if (slow_edge && presc_cnt_ff >= presc_reg_ff[5:0] + 6'h01) begin
			presc_cnt_ff <= 6'h00;
			tick_ff <= 1'b1;
		end else begin
			presc_cnt_ff <= slow_edge ? presc_cnt_ff + 6'h01 : presc_cnt_ff;
			tick_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			wake_cnt_ff <= 16'h0000;
			expire_ff <= 1'b0;
		end else if (tick_ff && wake_cnt_ff == coef - 16'h0001) begin
			wake_cnt_ff <= 16'h0000;
			expire_ff <= 1'b1;
		end else begin
			wake_cnt_ff <= tick_ff ? wake_cnt_ff + 16'h0001 : wake_cnt_ff;
			expire_ff <= 1'b0;
		end
	end

	// flag set wins over read clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_ff <= RST_CONTROL_STATUS[BIT_WAKE_FLAG];
		end else if (expire_ff) begin
			flag_ff <= 1'b1;
		end else if (rd_csts) begin
			flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			capture_ff <= measure_en_ff && slow_s2_ff;
			irq_ff <= flag_ff;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_FLAG_SET: assert property (expire_ff |=> flag_ff) else $error("flag not set at expiry");
	AST_READ_CLEARS: assert property (rd_csts && !expire_ff |=> !flag_ff) else $error("read left flag set");
	AST_WRITE_KEEPS: assert property (!rd_csts && !expire_ff |=> $stable(flag_ff))
		else $error("flag changed without cause");
	AST_DIV_RATIO: assert property (run && slow_edge && presc_cnt_ff == presc_reg_ff[5:0] + 6'h01
		##1 run |-> tick_ff) else $error("prescaler tick missing");
	AST_TB_OFF: assert property (tbc_ff == TB_OFF && $past(tbc_ff) == TB_OFF |-> !expire_ff)
		else $error("expiry with timebase off");
	AST_PERIOD: assert property (run && tick_ff && wake_cnt_ff == coef - 16'h0001 ##1 run
		|-> expire_ff && wake_cnt_ff == 16'h0000) else $error("period mismatch");
	AST_MEAS_BIT: assert property (wr_fire && wstrb_ff[0] && waddr_ff == OFS_CONTROL_STATUS
		&& wdata_ff[BIT_MEASURE_EN] |=> measure_en_ff) else $error("measure enable not stored");
	AST_MEAS_ROUTE: assert property (!measure_en_ff |=> !capture_ff)
		else $error("capture driven while disabled");
	AST_IRQ_FOLLOWS: assert property (wake_irq == $past(flag_ff)) else $error("irq not following flag");
	AST_ENABLE_SW: assert property (!wr_fire |=> $stable(wake_en_ff)) else $error("enable moved by hardware");
	AST_RESERVED: assert property (rvalid_ff |-> rdata_ff[31:8] == 24'h000000)
		else $error("reserved bits nonzero");

	COV_EXPIRE: cover property (run ##1 expire_ff);
	COV_READ_CLEAR: cover property (flag_ff && rd_csts ##1 !flag_ff);
	COV_CAPTURE: cover property (capture_ff ##1 !capture_ff);
endmodule

// ==== test/auto_wake_timer_tb.sv ====
`timescale 1ns/10ps
module auto_wake_timer_tb;
	import wake_timer_pkg::*;
	localparam int SP = 8; // slow clock period in aclk cycles
	localparam int LIMIT = 60000; // cycle ceiling for the whole run
	// bus and pin stimulus
	logic aclk = '0, aresetn = '0, slow = '0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = '0, wvalid = '0, arvalid = '0, bready = 1'h1, rready = 1'h1;
	logic awready, wready, arready, bvalid, rvalid, cap, wake_irq;
	logic [1:0] bresp, rresp, r;
	int cyc = 0, miscompares = 0, cmp_count = 0, c;
	auto_wake_timer auto_wake_timer_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .slow_internal_rc_clock(slow),
		.capture_timer_one_ch1(cap), .wake_irq(wake_irq));
	// clocks: the slow one runs free, as an rc oscillator does
	initial forever #2.5 aclk = ~aclk;
	initial forever begin
		repeat (SP / 2) @(posedge aclk);
		slow <= ~slow;
	end
	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// write: both channels offered together, each dropped when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		awaddr <= {28'h0, a};
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (bvalid !== 1'h1);
		r = bresp;
	endtask
	task automatic rd(input logic [3:0] a);
		araddr <= {28'h0, a};
		arvalid <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		rd(a);
		chk("read data", e, d);
	endtask
	task automatic wait_irq(input logic lvl);
		do @(posedge aclk); while (wake_irq !== lvl);
	endtask
	// counts rising edges of the capture route or of the wake request
	task automatic rises(input bit sel, input int n);
		logic p, v;
		c = 0;
		p = sel ? wake_irq : cap;
		repeat (n) begin
			@(posedge aclk);
			v = sel ? wake_irq : cap;
			if (v === 1'h1 && p === 1'h0) c++;
			p = v;
		end
	endtask
	task automatic t_regs();
		rc(OFS_CONTROL_STATUS, RST_CONTROL_STATUS);
		rc(OFS_PRESCALER, {24'h0, RST_PRESCALER});
		rc(OFS_TIMEBASE, {28'h0, RST_TIMEBASE});
		wr(OFS_CONTROL_STATUS, 32'hFFFF_FFFF);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
		rc(OFS_CONTROL_STATUS, 32'h11);
		rises(1'h1, 200);
		chk("irq with timebase off", 32'h0, c);
		rc(OFS_CONTROL_STATUS, 32'h11);
		wr(OFS_CONTROL_STATUS, 32'h0);
		wr(OFS_PRESCALER, 32'hFFFF_FFFE);
		rc(OFS_PRESCALER, 32'h3E);
		wr(OFS_PRESCALER, 32'hC0);
		rc(OFS_PRESCALER, 32'h0);
		wr(OFS_TIMEBASE, 32'hFFFF_FFF5);
		rc(OFS_TIMEBASE, 32'h5);
		wstrb <= 4'h0;
		wr(OFS_TIMEBASE, 32'h3);
		wstrb <= 4'hF;
		rc(OFS_TIMEBASE, 32'h5);
		wr(4'hC, 32'h1);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		rc(4'hC, 32'h0);
		chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
	endtask
	task automatic t_meas();
		wr(OFS_CONTROL_STATUS, 32'h1);
		rc(OFS_CONTROL_STATUS, 32'h1);
		rises(1'h0, 8 * SP);
		chk("capture edges", 32'h8, c);
		wr(OFS_CONTROL_STATUS, 32'h0);
		repeat (8) @(posedge aclk);
		rises(1'h0, 8 * SP);
		chk("capture edges off", 32'h0, c);
	endtask
	// interval between two expiries, with a write and a read in between
	task automatic tm(input logic [5:0] dv, input logic [3:0] tb, input int cf);
		int t1;
		wr(OFS_CONTROL_STATUS, 32'h0);
		wr(OFS_PRESCALER, {26'h0, dv});
		wr(OFS_TIMEBASE, {28'h0, tb});
		wr(OFS_CONTROL_STATUS, 32'h10);
		wait_irq(1'h1);
		t1 = cyc;
		wr(OFS_CONTROL_STATUS, 32'h10);
		rc(OFS_CONTROL_STATUS, 32'h30);
		wait_irq(1'h0);
		wait_irq(1'h1);
		chk("period", cf * (dv + 2) * SP, cyc - t1);
		rc(OFS_CONTROL_STATUS, 32'h30);
		rc(OFS_CONTROL_STATUS, 32'h10);
	endtask
	task automatic t_off();
		wr(OFS_CONTROL_STATUS, 32'h0);
		wr(OFS_PRESCALER, 32'h0);
		wr(OFS_TIMEBASE, 32'h1);
		rises(1'h1, 200);
		chk("irq while disabled", 32'h0, c);
		rc(OFS_CONTROL_STATUS, 32'h0);
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_regs();
		t_meas();
		tm(6'h00, 4'h1, 1);
		tm(6'h01, 4'h2, 2);
		tm(6'h04, 4'h3, 4);
		tm(6'h3E, 4'h1, 1);
		tm(6'h00, 4'hB, 1024);
		t_off();
		print_verdict();
	end
endmodule
